// File: include/rcss_pkg.sv
`default_nettype none
package rcss_pkg;
  // Start-up delay in system clock cycles.
  localparam int SST_CYCLES = 1024;
  localparam int SST_W = 11;
  // Wishbone byte addresses of the register words.
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_EVT_STATUS = 8'h04;
  localparam logic [7:0] ADR_EVT_CLEAR = 8'h08;
  localparam logic [7:0] ADR_EVT_ENABLE = 8'h0C;
  localparam logic [7:0] ADR_DELAY_COUNT = 8'h10;
  // Fields of the status word.
  localparam int ST_TIMEOUT_BIT = 0;
  localparam int ST_POWERDOWN_BIT = 1;
  localparam int ST_SLEEP_BIT = 2;
  localparam int ST_CORE_RESET_BIT = 3;
  localparam int ST_STALL_BIT = 4;
  localparam int ST_POWER_UP_BIT = 5;
  // Event bits shared by status, clear and enable words.
  localparam int EVT_W = 5;
  localparam int EV_PIN_RESET = 0;
  localparam int EV_PIN_WAKE = 1;
  localparam int EV_WDT_RESET = 2;
  localparam int EV_WARM_RESET = 3;
  localparam int EV_DELAY_DONE = 4;
  localparam logic [EVT_W-1:0] EVT_ENABLE_RST = 5'h00;
  // Values the core loads on chip reset.
  localparam logic [12:0] PC_RESET_VALUE = 13'h0000;
  localparam logic [2:0] SP_TOP_VALUE = 3'h0;
  localparam logic [7:0] WDT_SELECT_RESET = 8'h07;
  localparam logic [7:0] INT_CTRL_RESET = 8'h00;
  localparam logic [7:0] TMR0_CTRL_RESET = 8'h08;
  localparam logic [7:0] TMR1_CTRL_RESET = 8'h08;
  localparam logic [7:0] PORT8_RESET = 8'hFF;
  localparam logic [5:0] PORT6_RESET = 6'h3F;
  localparam logic PORT1_RESET = 1'b1;
  // Sequencer states.
  typedef enum logic [2:0] {SEQ_RUN, SEQ_SLEEP, SEQ_SYS_DLY, SEQ_WAKE_DLY, SEQ_WARM_DLY} rcss_state_e;
endpackage
`default_nettype wire

// File: design/rcss_sequencer.sv
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`default_nettype none
module rcss_sequencer (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic clk_en_in,
  input wire logic ext_reset_n_pin_in,
  input wire logic wdt_overflow_in,
  input wire logic halt_in,
  input wire logic clr_wdt_in,
  input wire logic wake_event_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic core_reset_out,
  output logic core_stall_out,
  output logic pc_sp_clear_out,
  output logic periph_reload_out,
  output logic regs_unknown_out,
  output logic watchdog_clear_out,
  output logic sleeping_out,
  output logic timeout_cause_flag_out,
  output logic powerdown_cause_flag_out,
  output logic irq_out
);
  import rcss_pkg::*;

  logic pin_s1_r;
  logic pin_s2_r;
  logic wdt_s1_r;
  logic wdt_s2_r;
  logic wdt_s3_r;
  logic pin_evt;
  logic wdt_evt;
  rcss_state_e state_r;
  rcss_state_e state_nxt;
  logic [SST_W-1:0] cnt_r;
  logic cnt_restart;
  logic cnt_done;
  logic to_r;
  logic to_nxt;
  logic pd_r;
  logic pd_nxt;
  logic power_up_r;
  logic [EVT_W-1:0] evt;
  logic [EVT_W-1:0] evt_sts_r;
  logic [EVT_W-1:0] evt_en_r;
  logic [EVT_W-1:0] evt_clr;
  logic [EVT_W-1:0] evt_sts_nxt;
  logic bus_req;
  logic bus_wr;
  logic [31:0] rd_data;

  // Two-stage synchronisers for the reset pin and the watchdog overflow.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      wdt_s1_r <= 1'b0;
      wdt_s2_r <= 1'b0;
      wdt_s3_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      pin_s1_r <= ext_reset_n_pin_in;
      pin_s2_r <= pin_s1_r;
      wdt_s1_r <= wdt_overflow_in;
      wdt_s2_r <= wdt_s1_r;
      wdt_s3_r <= wdt_s2_r;
    end
  end

  // Pin reset is a level; the watchdog overflow counts once per rising edge.
  assign pin_evt = ~pin_s2_r;
  assign wdt_evt = wdt_s2_r & ~wdt_s3_r;
  assign cnt_done = (cnt_r == SST_W'(SST_CYCLES - 1));

  // Next state, cause flags and delay restart.
  always_comb
  begin
    state_nxt = state_r;
    to_nxt = to_r;
    pd_nxt = pd_r;
    cnt_restart = 1'b0;
    evt = '0;
    unique case (state_r)
      SEQ_RUN:
      begin
        if (pin_evt)
        begin
          state_nxt = SEQ_SYS_DLY;
          cnt_restart = 1'b1;
          evt[EV_PIN_RESET] = 1'b1;
        end
        else if (wdt_evt)
        begin
          state_nxt = SEQ_SYS_DLY;
          to_nxt = 1'b1;
          cnt_restart = 1'b1;
          evt[EV_WDT_RESET] = 1'b1;
        end
        else if (halt_in)
        begin
          state_nxt = SEQ_SLEEP;
          pd_nxt = 1'b1;
          to_nxt = 1'b0;
        end
        else if (clr_wdt_in)
        begin
          pd_nxt = 1'b0;
        end
      end
      SEQ_SLEEP:
      begin
        if (pin_evt)
        begin
          state_nxt = SEQ_SYS_DLY;
          to_nxt = 1'b0;
          pd_nxt = 1'b1;
          cnt_restart = 1'b1;
          evt[EV_PIN_WAKE] = 1'b1;
        end
        else if (wdt_evt)
        begin
          state_nxt = SEQ_WARM_DLY;
          to_nxt = 1'b1;
          pd_nxt = 1'b1;
          cnt_restart = 1'b1;
          evt[EV_WARM_RESET] = 1'b1;
        end
        else if (wake_event_in)
        begin
          state_nxt = SEQ_WAKE_DLY;
          cnt_restart = 1'b1;
        end
      end
      SEQ_SYS_DLY, SEQ_WAKE_DLY, SEQ_WARM_DLY:
      begin
        if (pin_evt)
        begin
          state_nxt = SEQ_SYS_DLY;
          cnt_restart = 1'b1;
          evt[EV_PIN_RESET] = (state_r != SEQ_SYS_DLY);
        end
        else if (wdt_evt && state_r != SEQ_WARM_DLY)
        begin
          state_nxt = SEQ_SYS_DLY;
          to_nxt = 1'b1;
          cnt_restart = 1'b1;
          evt[EV_WDT_RESET] = 1'b1;
        end
        else if (cnt_done)
        begin
          state_nxt = SEQ_RUN;
          evt[EV_DELAY_DONE] = 1'b1;
        end
      end
    endcase
  end

  // Sequencer state; power-on starts in the system delay with flags 0,0.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_r <= SEQ_SYS_DLY;
      to_r <= 1'b0;
      pd_r <= 1'b0;
    end
    else if (clk_en_in)
    begin
      state_r <= state_nxt;
      to_r <= to_nxt;
      pd_r <= pd_nxt;
    end
  end

  // Start-up delay counter, restarted before expiry by a pin reset, or by a watchdog overflow outside the warm delay.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      cnt_r <= '0;
    end
    else if (clk_en_in)
    begin
      if (cnt_restart)
        cnt_r <= '0;
      else if (state_r == SEQ_SYS_DLY || state_r == SEQ_WAKE_DLY || state_r == SEQ_WARM_DLY)
        cnt_r <= cnt_r + SST_W'(1);
    end
  end

  // Power-up marker stays until the first system delay ends.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      power_up_r <= 1'b1;
    end
    else if (clk_en_in && state_nxt == SEQ_RUN)
    begin
      power_up_r <= 1'b0;
    end
  end

  // Reset controls for the core, watchdog and peripheral registers.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      core_reset_out <= 1'b1;
      core_stall_out <= 1'b0;
      pc_sp_clear_out <= 1'b1;
      periph_reload_out <= 1'b1;
      regs_unknown_out <= 1'b1;
      watchdog_clear_out <= 1'b1;
      sleeping_out <= 1'b0;
      timeout_cause_flag_out <= 1'b0;
      powerdown_cause_flag_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      core_reset_out <= (state_nxt == SEQ_SYS_DLY);
      core_stall_out <= (state_nxt == SEQ_WAKE_DLY) || (state_nxt == SEQ_WARM_DLY);
      pc_sp_clear_out <= (state_nxt == SEQ_SYS_DLY) || (state_nxt == SEQ_WARM_DLY);
      periph_reload_out <= (state_nxt == SEQ_SYS_DLY);
      regs_unknown_out <= power_up_r && (state_nxt == SEQ_SYS_DLY);
      watchdog_clear_out <= (state_nxt == SEQ_SYS_DLY) || (state_r == SEQ_RUN && state_nxt == SEQ_SLEEP)
        || (state_r == SEQ_RUN && clr_wdt_in);
      sleeping_out <= (state_nxt == SEQ_SLEEP);
      timeout_cause_flag_out <= to_nxt;
      powerdown_cause_flag_out <= pd_nxt;
    end
  end

  // Bus request decode; a request is taken in the cycle before ack.
  assign bus_req = wb_cyc_in & wb_stb_in & ~wb_ack_out;
  assign bus_wr = bus_req & wb_we_in & wb_sel_in[0];
  assign evt_clr = (bus_wr && wb_adr_in == ADR_EVT_CLEAR) ? wb_dat_in[EVT_W-1:0] : '0;
  // A new event wins over a clear in the same cycle.
  assign evt_sts_nxt = (evt_sts_r & ~evt_clr) | evt;

  // Sticky event status, enable word and the interrupt line.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      evt_sts_r <= '0;
      evt_en_r <= EVT_ENABLE_RST;
      irq_out <= 1'b0;
    end
    else if (clk_en_in)
    begin
      evt_sts_r <= evt_sts_nxt;
      if (bus_wr && wb_adr_in == ADR_EVT_ENABLE)
        evt_en_r <= wb_dat_in[EVT_W-1:0];
      irq_out <= |(evt_sts_nxt & evt_en_r);
    end
  end

  // Read multiplexer; unmapped addresses read as zero.
  always_comb
  begin
    rd_data = '0;
    unique case (wb_adr_in)
      ADR_STATUS:
      begin
        rd_data[ST_TIMEOUT_BIT] = to_r;
        rd_data[ST_POWERDOWN_BIT] = pd_r;
        rd_data[ST_SLEEP_BIT] = (state_r == SEQ_SLEEP);
        rd_data[ST_CORE_RESET_BIT] = (state_r == SEQ_SYS_DLY);
        rd_data[ST_STALL_BIT] = (state_r == SEQ_WAKE_DLY) || (state_r == SEQ_WARM_DLY);
        rd_data[ST_POWER_UP_BIT] = power_up_r;
      end
      ADR_EVT_STATUS: rd_data[EVT_W-1:0] = evt_sts_r;
      ADR_EVT_ENABLE: rd_data[EVT_W-1:0] = evt_en_r;
      ADR_DELAY_COUNT: rd_data[SST_W-1:0] = cnt_r;
      default: rd_data = '0;
    endcase
  end

  // Single-wait acknowledge, dropped in the following cycle.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end
    else if (clk_en_in)
    begin
      wb_ack_out <= bus_req;
      if (bus_req)
        wb_dat_out <= rd_data;
    end
  end
endmodule
`default_nettype wire

// File: bench/rcss_sva.sv
`default_nettype none
module rcss_sva
  import rcss_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ext_reset_n_pin_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic core_reset_out,
  input wire logic core_stall_out,
  input wire logic pc_sp_clear_out,
  input wire logic periph_reload_out,
  input wire logic regs_unknown_out,
  input wire logic watchdog_clear_out,
  input wire logic sleeping_out,
  input wire logic timeout_cause_flag_out,
  input wire logic powerdown_cause_flag_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  logic [15:0] busy_cnt_r;
  // Counts how long the core has been held in reset or stalled.
  always_ff @(posedge clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      busy_cnt_r <= 16'h0000;
    else if (core_reset_out || core_stall_out)
      busy_cnt_r <= busy_cnt_r + 16'h0001;
    else
      busy_cnt_r <= 16'h0000;
  end
  // Bus answers and the reset outputs against their causes.
  a_ack_single: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack longer than one cycle");
  a_ack_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("no ack");
  a_delay_length: assert property ($fell(core_reset_out || core_stall_out) |-> busy_cnt_r >= 16'(SST_CYCLES))
    else $error("start-up delay too short");
  a_core_reset_scope: assert property (core_reset_out |-> pc_sp_clear_out && watchdog_clear_out)
    else $error("core reset without pc or watchdog clear");
  a_warm_keeps_regs: assert property (core_stall_out |-> !periph_reload_out && !core_reset_out)
    else $error("stall reloads registers");
  a_unknown_poweron: assert property (regs_unknown_out |-> core_reset_out && !timeout_cause_flag_out)
    else $error("unknown outside power-on delay");
  a_warm_flag_pair: assert property ($rose(core_stall_out) && pc_sp_clear_out |->
    timeout_cause_flag_out && powerdown_cause_flag_out) else $error("warm flags wrong");
  a_pin_reset_now: assert property (!ext_reset_n_pin_in [*4] |-> core_reset_out)
    else $error("pin reset not taken");
  a_sleep_flag_set: assert property ($rose(sleeping_out) |-> powerdown_cause_flag_out && !timeout_cause_flag_out)
    else $error("sleep flags wrong");
  a_reload_in_reset: assert property (periph_reload_out |-> core_reset_out) else $error("reload outside reset");
  // Main scenarios seen.
  c_warm_end: cover property ($fell(core_stall_out));
  c_sleep: cover property ($rose(sleeping_out));
  c_reset_end: cover property ($fell(core_reset_out));
endmodule
bind rcss_sequencer rcss_sva u_sva (.clk_in, .rst_b_in, .ext_reset_n_pin_in, .wb_cyc_in, .wb_stb_in, .wb_ack_out,
  .core_reset_out, .core_stall_out, .pc_sp_clear_out, .periph_reload_out, .regs_unknown_out, .watchdog_clear_out,
  .sleeping_out, .timeout_cause_flag_out, .powerdown_cause_flag_out);
`default_nettype wire

// File: bench/rcss_far_model.sv
`default_nettype none
module rcss_far_model (
  input wire logic clk_in,
  output logic pin_n_out,
  output logic wdt_ovf_out,
  output logic halt_out,
  output logic clr_out,
  output logic wake_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // Idle levels: pin released high, no events.
  initial
  begin
    pin_n_out = 1'b1;
    wdt_ovf_out = 1'b0;
    {halt_out, clr_out, wake_out} = 3'h0;
  end
  // Holds the reset pin low for a number of cycles.
  task automatic pin_low(input int n);
    @(posedge clk_in);
    pin_n_out <= 1'b0;
    repeat (n) @(posedge clk_in);
    pin_n_out <= 1'b1;
  endtask
  // Overflow level stays up long enough to cross the synchroniser.
  task automatic wdt_tick();
    @(posedge clk_in);
    wdt_ovf_out <= 1'b1;
    repeat (4) @(posedge clk_in);
    wdt_ovf_out <= 1'b0;
  endtask
  // One-cycle pulse of wake, clear-watchdog and halt, by mask.
  task automatic strobe(input logic [2:0] m);
    @(posedge clk_in);
    {wake_out, clr_out, halt_out} <= m;
    @(posedge clk_in);
    {wake_out, clr_out, halt_out} <= 3'h0;
  endtask
endmodule
`default_nettype wire

// File: bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import rcss_pkg::*;
  logic clk_in = 1'b0, rst_b_in = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, en = 1'b1;
  logic [3:0] sel = 4'hF;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic pin_n, wdt, halt, clr, wake, ack, core_rst, stall, pcsp, reload, unk, slp, to, pd, irq, wclr;
  int failures = 0, tests_run = 0, n;
  rcss_far_model far (.clk_in(clk_in), .pin_n_out(pin_n), .wdt_ovf_out(wdt), .halt_out(halt), .clr_out(clr),
    .wake_out(wake));
  rcss_sequencer dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .clk_en_in(en), .ext_reset_n_pin_in(pin_n),
    .wdt_overflow_in(wdt), .halt_in(halt), .clr_wdt_in(clr), .wake_event_in(wake), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
    .wb_ack_out(ack), .core_reset_out(core_rst), .core_stall_out(stall), .pc_sp_clear_out(pcsp),
    .periph_reload_out(reload), .regs_unknown_out(unk), .watchdog_clear_out(wclr), .sleeping_out(slp),
    .timeout_cause_flag_out(to), .powerdown_cause_flag_out(pd), .irq_out(irq));
  // Free-running 40 MHz system clock.
  initial
  begin
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Classic single Wishbone cycle, held until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk_in);
    {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
    k = 0;
    do @(posedge clk_in); while (ack !== 1'b1 && ++k < 50);
    // A missing answer counts as a mismatch.
    if (ack !== 1'b1)
    begin
      failures++;
      $display("unexpected ack expected 1 seen %b", ack);
    end
    q = rdat;
    {cyc, stb, we} <= 3'b000;
  endtask
  // Waits until the core leaves reset and stall.
  task automatic settle();
    n = 0;
    while ((core_rst | stall) !== 1'b0 && n < 3000)
    begin
      @(posedge clk_in);
      n++;
    end
    #1;
  endtask
  // Optional sleep, then one wake or reset cause, then the delay.
  task automatic scen(input string nm, input bit sl, input int kind, input logic [5:0] e);
    if (sl)
    begin
      far.strobe(3'b001);
      #1;
      chk("sleep_flags", 32'h5, {29'h0, slp, to, pd});
    end
    case (kind)
      0: far.pin_low(8);
      1: far.wdt_tick();
      default: far.strobe(3'b100);
    endcase
    @(posedge clk_in);
    #1;
    chk(nm, {26'h0, e}, {26'h0, core_rst, stall, pcsp, reload, to, pd});
    settle();
    chk("delay", 32'h1, 32'(n >= SST_CYCLES - 1 && n <= SST_CYCLES + 2));
    $display("test %s done", nm);
  endtask
  // Watchdog against a hang.
  initial
  begin
    #750000;
    failures++;
    close_out();
  end
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge clk_in);
    #1;
    chk("power_up", 32'h2, {30'h0, unk, to | pd});
    @(posedge clk_in);
    rst_b_in <= 1'b1;
    settle();
    chk("power_delay", 32'h1, 32'(n >= SST_CYCLES && n <= SST_CYCLES + 2));
    $display("test power_up done");
    wb(1'b1, ADR_EVT_CLEAR, 32'h1F);
    wb(1'b1, ADR_EVT_ENABLE, 32'h4);
    scen("run_wdt", 1'b0, 1, 6'b101110);
    chk("irq_raised", 32'h1, {31'h0, irq});
    wb(1'b0, ADR_EVT_STATUS, 32'h0);
    chk("evt_status", 32'h1, {31'h0, q[EV_WDT_RESET]});
    wb(1'b1, ADR_EVT_ENABLE, 32'h0);
    #1;
    chk("irq_masked", 32'h0, {31'h0, irq});
    wb(1'b1, ADR_EVT_CLEAR, 32'h1F);
    wb(1'b1, ADR_EVT_ENABLE, 32'h4);
    #1;
    chk("irq_cleared", 32'h0, {31'h0, irq});
    wb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, q);
    // A write without byte lane 0 must leave the enable word alone.
    sel <= 4'hE;
    wb(1'b1, ADR_EVT_ENABLE, 32'h0);
    sel <= 4'hF;
    wb(1'b0, ADR_EVT_ENABLE, 32'h0);
    chk("sel_ignored", 32'h4, q);
    // A halt while the clock enable is low must not reach the sequencer.
    @(posedge clk_in);
    en <= 1'b0;
    far.strobe(3'b001);
    #1;
    chk("frozen", 32'h0, {31'h0, slp});
    @(posedge clk_in);
    en <= 1'b1;
    $display("test bus done");
    scen("warm", 1'b1, 1, 6'b011011);
    scen("run_pin", 1'b0, 0, 6'b101111);
    scen("wake", 1'b1, 2, 6'b010001);
    scen("pin_halt", 1'b1, 0, 6'b101101);
    far.strobe(3'b010);
    #1;
    chk("clr_wdt", 32'h1, {29'h0, to, pd, wclr});
    $display("test clr_wdt done");
    close_out();
  end
endmodule
`default_nettype wire
